// ===== rtl/dac_pkg.sv
// Constants for the twelve-channel double-buffered converter control block.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
// How it works
// - There are twelve channels, each holding a 12-bit output code.
// - In synchronous mode a write lands in the input register first, the latch later.
// - On a load the latch copies the input register if select is one and it was written since.
// - In synchronous mode the latch takes the input only on writing one to the trigger or on leaving clear.
// - In asynchronous mode the latch passes written data straight through.
// - Reading a channel's data location returns the latch, not the input.
// - One gain bit per channel picks twice or five times reference range.
// - After power-up every output buffer starts powered down.
// - Reset clears every input register and every latch to zero.
// - With select at zero a data write updates the latch at once.
// - A trigger updates together all channels whose select bit is one and that hold a new write.
// - A trigger reloads only channels written since the last trigger that had them selected.
// - A clear loads the clear code at once and leaves the input alone.
package dac_pkg;
  localparam int CHANNELS = 12;
  localparam int CODE_W = 12;
  localparam logic [5:0] IDX_DATA_BASE = 6'h00;
  localparam logic [5:0] IDX_SYNC_SEL = 6'h0C;
  localparam logic [5:0] IDX_GAIN = 6'h0D;
  localparam logic [5:0] IDX_CONFIG = 6'h0E;
  localparam logic [5:0] IDX_CLEAR = 6'h0F;
  localparam logic [5:0] IDX_POWER = 6'h10;
  localparam logic [5:0] IDX_CLR_CODE_BASE = 6'h20;
  localparam int LOAD_TRIGGER_BIT = 0;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [11:0] MASK_RESET = 12'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/dac_channel.sv
// One converter channel: input register, output latch, clear code.
// Assumes strobes are one-cycle pulses on the same clock.
module dac_channel
(
  input wire logic clock,
  input wire logic rst,
  input wire logic dataWr,
  input wire logic codeWr,
  input wire logic [11:0] wrValue,
  input wire logic syncSel,
  input wire logic loadPulse,
  input wire logic clear,
  output logic [11:0] dataReg,
  output logic [11:0] latch,
  output logic [11:0] clearCode
);
  logic dirty;
  logic clearing;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dataReg <= dac_pkg::CODE_RESET;
    end
    else if (dataWr)
    begin
      dataReg <= wrValue;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      clearCode <= dac_pkg::CODE_RESET;
    end
    else if (codeWr)
    begin
      clearCode <= wrValue;
    end
  end

  // Set wins: a write in the trigger cycle stays pending for the next one
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dirty <= 1'b0;
    end
    else if (dataWr)
    begin
      dirty <= 1'b1;
    end
    else if (loadPulse && syncSel)
    begin
      dirty <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      clearing <= 1'b0;
    end
    else
    begin
      clearing <= clear;
    end
  end

  // Leaving clear restores the input register regardless of mode
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      latch <= dac_pkg::CODE_RESET;
    end
    else if (clear)
    begin
      latch <= clearCode;
    end
    // Async write in the release cycle wins, else it would be lost
    else if (dataWr && !syncSel)
    begin
      latch <= wrValue;
    end
    else if (clearing)
    begin
      latch <= dataReg;
    end
    else if (loadPulse && syncSel && dirty)
    begin
      latch <= dataReg;
    end
  end

  a_reset_zero: assert property (@(posedge clock)
    rst |=> latch == 12'h000 && dataReg == 12'h000)
    else $error("latch or input not zero after reset");

  a_async_pass: assert property (@(posedge clock) disable iff (rst)
    dataWr && !syncSel && !clear && !clearing |=> latch == $past(wrValue))
    else $error("async write did not reach latch");

  a_sync_hold: assert property (@(posedge clock) disable iff (rst)
    dataWr && syncSel && !loadPulse && !clear && !clearing
      |=> latch == $past(latch) && dataReg == $past(wrValue))
    else $error("sync write changed latch");

  a_sync_load: assert property (@(posedge clock) disable iff (rst)
    loadPulse && syncSel && dirty && !clear && !clearing
      |=> latch == $past(dataReg))
    else $error("trigger did not load latch");

  a_clean_keep: assert property (@(posedge clock) disable iff (rst)
    loadPulse && syncSel && !dirty && !clear && !clearing
      |=> $stable(latch))
    else $error("untouched channel reloaded");

  a_clear_load: assert property (@(posedge clock) disable iff (rst)
    clear && !dataWr |=> latch == $past(clearCode) && $stable(dataReg))
    else $error("clear did not load clear code");
endmodule

// ===== rtl/dac_ctrl_top.sv
// Register front end and twelve converter channels behind AXI4-Lite.
// Assumes a single clock; the bus master keeps AXI valid/hold ordering.
//
// Chosen here: register access over AXI4-Lite and the address map.
module dac_ctrl_top
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [11:0] dacCode [12],
  output logic [11:0] gainFive,
  output logic [11:0] outputEnable
);
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic awHave;
  logic wHave;
  logic doWrite;
  logic [5:0] wIdx;
  logic [5:0] rIdx;
  logic [11:0] syncSel;
  logic [11:0] swClear;
  logic loadPulse;
  logic [11:0] dataReg [12];
  logic [11:0] clearCode [12];

  function automatic logic [11:0] merge12(input logic [11:0] old,
    input logic [31:0] wd, input logic [3:0] st);
    logic [11:0] v;
    v = old;
    if (st[0])
    begin
      v[7:0] = wd[7:0];
    end
    if (st[1])
    begin
      v[11:8] = wd[11:8];
    end
    return v;
  endfunction

  assign doWrite = awHave && wHave && !bvalid;
  assign wIdx = wrAddr[7:2];
  assign rIdx = araddr[7:2];

  // Address and data are taken independently, in either order
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      awready <= 1'b0;
      awHave <= 1'b0;
      wrAddr <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      awHave <= 1'b1;
      wrAddr <= awaddr;
    end
    else if (doWrite)
    begin
      awHave <= 1'b0;
    end
    else if (!awHave && !bvalid)
    begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wready <= 1'b0;
      wHave <= 1'b0;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      wHave <= 1'b1;
      wrData <= wdata;
      wrStrb <= wstrb;
    end
    else if (doWrite)
    begin
      wHave <= 1'b0;
    end
    else if (!wHave && !bvalid)
    begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp <= dac_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      if (wIdx <= dac_pkg::IDX_POWER
          || (wIdx >= dac_pkg::IDX_CLR_CODE_BASE
              && wIdx < dac_pkg::IDX_CLR_CODE_BASE + 6'h0C))
      begin
        bresp <= dac_pkg::RESP_OKAY;
      end
      else
      begin
        bresp <= dac_pkg::RESP_SLVERR;
      end
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      syncSel <= dac_pkg::MASK_RESET;
      gainFive <= dac_pkg::MASK_RESET;
      swClear <= dac_pkg::MASK_RESET;
      outputEnable <= dac_pkg::MASK_RESET;
    end
    else if (doWrite)
    begin
      case (wIdx)
        dac_pkg::IDX_SYNC_SEL: syncSel <= merge12(syncSel, wrData, wrStrb);
        dac_pkg::IDX_GAIN: gainFive <= merge12(gainFive, wrData, wrStrb);
        dac_pkg::IDX_CLEAR: swClear <= merge12(swClear, wrData, wrStrb);
        dac_pkg::IDX_POWER:
          outputEnable <= merge12(outputEnable, wrData, wrStrb);
        default: ;
      endcase
    end
  end

  // Self-clearing strobe, never stored, so it reads back as zero
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      loadPulse <= 1'b0;
    end
    else
    begin
      loadPulse <= doWrite && wIdx == dac_pkg::IDX_CONFIG && wrStrb[0]
        && wrData[dac_pkg::LOAD_TRIGGER_BIT];
    end
  end

  generate
    for (genvar i = 0; i < dac_pkg::CHANNELS; i++)
    begin : g_chan
      dac_channel u_chan
      (
        .clock(clock),
        .rst(rst),
        .dataWr(doWrite && wIdx == dac_pkg::IDX_DATA_BASE + 6'(i)),
        .codeWr(doWrite && wIdx == dac_pkg::IDX_CLR_CODE_BASE + 6'(i)),
        .wrValue(wIdx < dac_pkg::IDX_SYNC_SEL
          ? merge12(dataReg[i], wrData, wrStrb)
          : merge12(clearCode[i], wrData, wrStrb)),
        .syncSel(syncSel[i]),
        .loadPulse(loadPulse),
        .clear(swClear[i]),
        .dataReg(dataReg[i]),
        .latch(dacCode[i]),
        .clearCode(clearCode[i])
      );
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= dac_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= dac_pkg::RESP_OKAY;
      rdata <= 32'h00000000;
      if (rIdx < dac_pkg::IDX_SYNC_SEL)
      begin
        rdata <= {20'h00000, dacCode[rIdx[3:0]]};
      end
      else if (rIdx >= dac_pkg::IDX_CLR_CODE_BASE
               && rIdx < dac_pkg::IDX_CLR_CODE_BASE + 6'h0C)
      begin
        rdata <= {20'h00000, clearCode[rIdx[3:0]]};
      end
      else
      begin
        case (rIdx)
          dac_pkg::IDX_SYNC_SEL: rdata <= {20'h00000, syncSel};
          dac_pkg::IDX_GAIN: rdata <= {20'h00000, gainFive};
          dac_pkg::IDX_CONFIG: rdata <= 32'h00000000;
          dac_pkg::IDX_CLEAR: rdata <= {20'h00000, swClear};
          dac_pkg::IDX_POWER: rdata <= {20'h00000, outputEnable};
          default: rresp <= dac_pkg::RESP_SLVERR;
        endcase
      end
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
    end
    else if (!rvalid)
    begin
      arready <= 1'b1;
    end
  end

  a_trigger_once: assert property (@(posedge clock) disable iff (rst)
    loadPulse |=> !loadPulse)
    else $error("load pulse longer than one cycle");

  a_trigger_cause: assert property (@(posedge clock) disable iff (rst)
    loadPulse |-> $past(doWrite) && $past(wIdx) == dac_pkg::IDX_CONFIG)
    else $error("load pulse without trigger write");

  a_power_down: assert property (@(posedge clock)
    rst |=> outputEnable == 12'h000 && gainFive == 12'h000)
    else $error("outputs not powered down after reset");

  a_read_latch: assert property (@(posedge clock) disable iff (rst)
    arvalid && arready && araddr[7:2] == 6'h03
      |=> rdata == {20'h00000, $past(dacCode[3])})
    else $error("data read did not return latch");

  a_bresp_hold: assert property (@(posedge clock) disable iff (rst)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
endmodule

// ===== tb/tb_dac_ctrl_top.sv
// Bench for the twelve-channel converter control block.
// Assumes the register map in dac_pkg; it drives AXI4-Lite directly.
module tb_dac_ctrl_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [11:0] dacCode [12];
  logic [11:0] gainFive, outputEnable;
  int errors, checks;

  dac_ctrl_top u_dut (.clock(clock), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .dacCode(dacCode), .gainFive(gainFive),
    .outputEnable(outputEnable));

  always #4 clock = ~clock;

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("FAIL t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  // Waits are bounded; a hung handshake ends the run
  task automatic wr(input logic [5:0] idx, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      // Late bready makes the response wait one cycle
      if (bvalid === 1'b1 && !bready)
        bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready) && n < 50);
    if (bready)
      bready <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      summarize();
    end
    check(bresp, er);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 50);
    rready <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      summarize();
    end
    check(rdata, e);
    check(rresp, er);
  endtask

  task automatic resetCheck();
    @(posedge clock);
    for (int i = 0; i < 12; i++)
      check(dacCode[i], 32'h0);
    check(outputEnable, 32'h0);
    check(gainFive, 32'h0);
    $display("reset test done");
  endtask

  localparam logic [1:0] OK = dac_pkg::RESP_OKAY;

  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    errors = 0;
    checks = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    resetCheck();
    rd(dac_pkg::IDX_DATA_BASE + 6'h3, 32'h0, OK);
    // Asynchronous channel follows each write
    wr(dac_pkg::IDX_DATA_BASE + 6'h3, 32'hABC, OK);
    @(posedge clock);
    check(dacCode[3], 32'hABC);
    rd(dac_pkg::IDX_DATA_BASE + 6'h3, 32'hABC, OK);
    $display("async test done");
    // Synchronous channels hold until the trigger
    wr(dac_pkg::IDX_SYNC_SEL, 32'h3, OK);
    wr(dac_pkg::IDX_DATA_BASE, 32'h123, OK);
    wr(dac_pkg::IDX_DATA_BASE + 6'h1, 32'h456, OK);
    @(posedge clock);
    check(dacCode[0], 32'h0);
    check(dacCode[1], 32'h0);
    rd(dac_pkg::IDX_DATA_BASE, 32'h0, OK);
    wr(dac_pkg::IDX_CONFIG, 32'h1, OK);
    @(posedge clock);
    check(dacCode[0], 32'h123);
    check(dacCode[1], 32'h456);
    check(dacCode[3], 32'hABC);
    rd(dac_pkg::IDX_CONFIG, 32'h0, OK);
    // A single pulse: later writes stay pending
    wr(dac_pkg::IDX_DATA_BASE + 6'h1, 32'h999, OK);
    repeat (4) @(posedge clock);
    check(dacCode[1], 32'h456);
    wr(dac_pkg::IDX_DATA_BASE, 32'h777, OK);
    wr(dac_pkg::IDX_CONFIG, 32'h1, OK);
    @(posedge clock);
    check(dacCode[0], 32'h777);
    check(dacCode[1], 32'h999);
    // Trigger with nothing written: no channel is reloaded
    wr(dac_pkg::IDX_CONFIG, 32'h1, OK);
    @(posedge clock);
    check(dacCode[0], 32'h777);
    check(dacCode[1], 32'h999);
    $display("sync test done");
    wr(dac_pkg::IDX_GAIN, 32'hA5A, OK);
    wr(dac_pkg::IDX_POWER, 32'h5A5, OK);
    check(gainFive, 32'hA5A);
    check(outputEnable, 32'h5A5);
    rd(dac_pkg::IDX_GAIN, 32'hA5A, OK);
    $display("gain test done");
    // Clear overrides the latch, input register survives
    wr(dac_pkg::IDX_CLR_CODE_BASE + 6'h3, 32'h3C3, OK);
    wr(dac_pkg::IDX_CLEAR, 32'h8, OK);
    @(posedge clock);
    check(dacCode[3], 32'h3C3);
    wr(dac_pkg::IDX_CLEAR, 32'h0, OK);
    repeat (2) @(posedge clock);
    check(dacCode[3], 32'hABC);
    $display("clear test done");
    // Low byte lane only: bits 11:8 keep their old value
    wstrb <= 4'h1;
    wr(dac_pkg::IDX_DATA_BASE + 6'h3, 32'h12345, OK);
    wstrb <= 4'hF;
    @(posedge clock);
    check(dacCode[3], 32'hA45);
    $display("byte lane test done");
    wr(6'h11, 32'hFFF, dac_pkg::RESP_SLVERR);
    rd(6'h11, 32'h0, dac_pkg::RESP_SLVERR);
    $display("unmapped test done");
    // Second reset in mid-run
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    resetCheck();
    rd(dac_pkg::IDX_SYNC_SEL, 32'h0, OK);
    $display("second reset test done");
    summarize();
  end
endmodule
